// [rtl/iofr_router.sv]
// Purpose: routes connector pins and virtual bits to drive functions
// Assumes: register port strobes one cycle, read data next cycle
// Notes: map writes stay pending until the apply bit is written
//
// Operation
// - eight connector pins, mapped by two maps
// - eight virtual bits, mapped by two maps
// - written code attaches function to input
// - each input circuit carries one code, so drives one function
// - duplicated function: highest priority source wins
// - pins first in order, then virtual bits
// - codes 00-05 basic servo inputs
// - codes 06-0f limits, jog, homing, clamp
// - codes 10-14 torque contacts, limits, negate
// - codes 15-19 point index; 1a-1c inert
// - three output groups from one map
// - output group ORs all allocated functions
// - output codes 0-4 status and brake
// - codes 5-9 status, a-c remote outputs
// - per-pin polarity inverts logical sense
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "iofr_defines.svh"
module iofr_router #(
    parameter int NPIN = 8,
    parameter int NVIN = 8,
    parameter int NGRP = 3
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // connector inputs
    input wire logic [NPIN-1:0] i_pins,
    // internal status for codes 0 to 9
    input wire logic [9:0] i_out_funcs,
    // routed input functions, index is the code
    output logic [`IOFR_NUM_IN_FUNCS-1:0] o_funcs,
    // connector output groups
    output logic [NGRP-1:0] o_out_pins
);

    localparam int NSRC = NPIN + NVIN;

    // ---------------------------------------------------------------
    // pending configuration
    // ---------------------------------------------------------------
    logic [31:0] in_map_a_ff;
    logic [31:0] in_map_b_ff;
    logic [31:0] vin_map_a_ff;
    logic [31:0] vin_map_b_ff;
    logic [23:0] out_map_ff;
    logic [NVIN-1:0] vin_bits_ff;
    logic [10:0] pol_ff;
    logic [2:0] remote_ff;
    logic [`IOFR_NUM_IN_FUNCS-1:0] funcs_ff;
    logic [NGRP-1:0] out_pins_ff;

    logic wr_in_a;
    logic wr_in_b;
    logic wr_vin_a;
    logic wr_vin_b;
    logic wr_out;
    logic apply;

    assign wr_in_a = i_wr && (i_addr == `IOFR_OFS_IN_MAP_A);
    assign wr_in_b = i_wr && (i_addr == `IOFR_OFS_IN_MAP_B);
    assign wr_vin_a = i_wr && (i_addr == `IOFR_OFS_VIN_MAP_A);
    assign wr_vin_b = i_wr && (i_addr == `IOFR_OFS_VIN_MAP_B);
    assign wr_out = i_wr && (i_addr == `IOFR_OFS_OUT_MAP);
    assign apply = i_wr && (i_addr == `IOFR_OFS_APPLY) &&
                   i_wdata[`IOFR_APPLY_BIT];

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            in_map_a_ff <= `IOFR_RST_IN_MAP_A;
            in_map_b_ff <= `IOFR_RST_IN_MAP_B;
        end else begin
            if (wr_in_a) begin
                in_map_a_ff <= i_wdata;
            end
            if (wr_in_b) begin
                in_map_b_ff <= i_wdata;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            vin_map_a_ff <= `IOFR_RST_VIN_MAP;
            vin_map_b_ff <= `IOFR_RST_VIN_MAP;
        end else begin
            if (wr_vin_a) begin
                vin_map_a_ff <= i_wdata;
            end
            if (wr_vin_b) begin
                vin_map_b_ff <= i_wdata;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            out_map_ff <= `IOFR_RST_OUT_MAP;
        end else if (wr_out) begin
            out_map_ff <= i_wdata[23:0];
        end
    end

    // ---------------------------------------------------------------
    // live settings: virtual bits, remote outputs; polarity pending until apply
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            vin_bits_ff <= '0;
        end else if (i_wr && (i_addr == `IOFR_OFS_VIN_BITS)) begin
            vin_bits_ff <= i_wdata[NVIN-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pol_ff <= '0;
        end else if (i_wr && (i_addr == `IOFR_OFS_POLARITY)) begin
            pol_ff <= i_wdata[10:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            remote_ff <= '0;
        end else if (i_wr && (i_addr == `IOFR_OFS_REMOTE)) begin
            remote_ff <= i_wdata[2:0];
        end
    end

    // ---------------------------------------------------------------
    // active configuration, loaded only by apply
    // ---------------------------------------------------------------
    iofr_pkg::iofr_cfg_t act_ff;
    iofr_pkg::iofr_cfg_t nxt_act;

    always_comb begin
        nxt_act.in_map = {vin_map_b_ff, vin_map_a_ff,
                          in_map_b_ff, in_map_a_ff};
        nxt_act.out_map = out_map_ff;
        nxt_act.in_pol = pol_ff[7:0];
        nxt_act.out_pol = pol_ff[10:8];
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            act_ff.in_map <= {`IOFR_RST_VIN_MAP, `IOFR_RST_VIN_MAP,
                              `IOFR_RST_IN_MAP_B, `IOFR_RST_IN_MAP_A};
            act_ff.out_map <= `IOFR_RST_OUT_MAP;
            act_ff.in_pol <= '0;
            act_ff.out_pol <= '0;
        end else if (apply) begin
            act_ff <= nxt_act;
        end
    end

    apply_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (wr_in_a && !apply) |=> (act_ff.in_map == $past(act_ff.in_map)))
        else $error("map changed without apply");

    apply_copy_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        apply |=> (act_ff.out_map == $past(out_map_ff)) &&
                  (act_ff.in_pol == $past(pol_ff[7:0])))
        else $error("apply did not load pending maps");

    // ---------------------------------------------------------------
    // input sampling and routing
    // ---------------------------------------------------------------
    logic [NPIN-1:0] pins_ff;
    logic [NSRC-1:0] src_lvl;
    logic [`IOFR_NUM_IN_FUNCS-1:0] nxt_funcs;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pins_ff <= '0;
        end else begin
            pins_ff <= i_pins;
        end
    end

    // pins take polarity, virtual bits are logical already
    assign src_lvl = {vin_bits_ff, pins_ff ^ act_ff.in_pol};

    // codes 00-19 name functions in table order, 1a up match none
    iofr_src_select #(
        .NSRC(NSRC),
        .NFUNC(`IOFR_NUM_IN_FUNCS)
    ) u_sel (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_codes(act_ff.in_map),
        .i_lvl(src_lvl),
        .o_func(nxt_funcs)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            funcs_ff <= '0;
        end else begin
            funcs_ff <= nxt_funcs;
        end
    end

    assign o_funcs = funcs_ff;

    // helper: servo-on code present on any source
    logic son_used;
    always_comb begin
        son_used = 1'b0;
        for (int s = 0; s < NSRC; s++) begin
            if (act_ff.in_map[s] == 8'h00) begin
                son_used = 1'b1;
            end
        end
    end

    unalloc_low_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (!son_used && $stable(act_ff)) |=> !funcs_ff[0])
        else $error("unallocated function asserted");

    pin_sample_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        ##1 pins_ff == $past(i_pins))
        else $error("pin not sampled on clock");

    reserved_inert_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (act_ff.in_map[0] >= `IOFR_FIRST_RESERVED &&
         act_ff.in_map[NSRC-1:1] == {(NSRC-1){8'hff}})
        |-> nxt_funcs == '0)
        else $error("reserved code drove a function");

    pin0_pol_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (act_ff.in_map[0] == 8'h04) |->
        (nxt_funcs[4] == (pins_ff[0] ^ act_ff.in_pol[0])))
        else $error("pin polarity not applied");

    // ---------------------------------------------------------------
    // output groups
    // ---------------------------------------------------------------
    logic [`IOFR_NUM_OUT_FUNCS-1:0] out_src;
    logic [NGRP-1:0] nxt_out;

    // codes 0-9 internal status, a-c remote bits
    assign out_src = {remote_ff, i_out_funcs};

    genvar gg;
    generate
        for (gg = 0; gg < NGRP; gg++) begin : g_grp
            logic [3:0] c0;
            logic [3:0] c1;
            logic hit0;
            logic hit1;
            assign c0 = act_ff.out_map[2*gg];
            assign c1 = act_ff.out_map[2*gg+1];
            always_comb begin
                hit0 = 1'b0;
                hit1 = 1'b0;
                if (c0 < 4'(`IOFR_NUM_OUT_FUNCS)) begin
                    hit0 = out_src[c0];
                end
                if (c1 < 4'(`IOFR_NUM_OUT_FUNCS)) begin
                    hit1 = out_src[c1];
                end
            end
            // both slots may feed one circuit
            assign nxt_out[gg] = (hit0 | hit1) ^ act_ff.out_pol[gg];
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            out_pins_ff <= '0;
        end else begin
            out_pins_ff <= nxt_out;
        end
    end

    assign o_out_pins = out_pins_ff;

    out_or_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (act_ff.out_map[0] < 4'ha && act_ff.out_map[1] < 4'ha &&
         !act_ff.out_pol[0] &&
         (i_out_funcs[act_ff.out_map[0]] ||
          i_out_funcs[act_ff.out_map[1]]))
        |=> o_out_pins[0])
        else $error("output group missed an allocated function");

    out_none_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (act_ff.out_map[3:2] == 8'hff && !act_ff.out_pol[1])
        |=> !o_out_pins[1])
        else $error("unallocated output group driven");

    remote_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (act_ff.out_map[5:4] == {4'hf, `IOFR_REMOTE_CODE0} &&
         !act_ff.out_pol[2] && $stable(act_ff))
        |=> o_out_pins[2] == $past(remote_ff[0]))
        else $error("remote output not routed");

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    logic [31:0] nxt_rdata;
    logic [31:0] rdata_ff;

    always_comb begin
        nxt_rdata = '0;
        case (i_addr)
            `IOFR_OFS_IN_MAP_A: nxt_rdata = in_map_a_ff;
            `IOFR_OFS_IN_MAP_B: nxt_rdata = in_map_b_ff;
            `IOFR_OFS_VIN_MAP_A: nxt_rdata = vin_map_a_ff;
            `IOFR_OFS_VIN_MAP_B: nxt_rdata = vin_map_b_ff;
            `IOFR_OFS_OUT_MAP: nxt_rdata = {8'h00, out_map_ff};
            `IOFR_OFS_VIN_BITS: nxt_rdata = {24'h000000, vin_bits_ff};
            `IOFR_OFS_POLARITY: nxt_rdata = {21'h000000, pol_ff};
            `IOFR_OFS_REMOTE: nxt_rdata = {29'h00000000, remote_ff};
            `IOFR_OFS_FUNC_STAT: nxt_rdata = {6'h00, funcs_ff};
            `IOFR_OFS_PIN_STAT: nxt_rdata = {21'h000000,
                                             out_pins_ff, pins_ff};
            default: nxt_rdata = '0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rdata_ff <= `IOFR_RST_ZERO;
        end else if (i_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= `IOFR_RST_ZERO;
        end
    end

    assign o_rdata = rdata_ff;

    unmapped_zero_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_rd && i_addr > `IOFR_OFS_PIN_STAT) |=> o_rdata == '0)
        else $error("unmapped read not zero");

endmodule // iofr_router

// [rtl/iofr_defines.svh]
// Purpose: constants of the io function router
// Assumes: word-aligned byte offsets on the plain register port
// Notes: definitions only
`ifndef IOFR_DEFINES_SVH
`define IOFR_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define IOFR_OFS_IN_MAP_A 8'h00
`define IOFR_OFS_IN_MAP_B 8'h04
`define IOFR_OFS_VIN_MAP_A 8'h08
`define IOFR_OFS_VIN_MAP_B 8'h0c
`define IOFR_OFS_OUT_MAP 8'h10
`define IOFR_OFS_VIN_BITS 8'h14
`define IOFR_OFS_POLARITY 8'h18
`define IOFR_OFS_REMOTE 8'h1c
`define IOFR_OFS_APPLY 8'h20
`define IOFR_OFS_FUNC_STAT 8'h24
`define IOFR_OFS_PIN_STAT 8'h28

// ---------------------------------------------------------------
// field positions and codes
// ---------------------------------------------------------------
`define IOFR_APPLY_BIT 0
`define IOFR_OUT_POL_LSB 8
`define IOFR_NUM_IN_FUNCS 26
`define IOFR_NUM_OUT_FUNCS 13
`define IOFR_FIRST_RESERVED 8'h1a
`define IOFR_REMOTE_CODE0 4'ha

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define IOFR_RST_IN_MAP_A 32'h03020100
`define IOFR_RST_IN_MAP_B 32'h07060504
`define IOFR_RST_VIN_MAP 32'hffffffff
`define IOFR_RST_OUT_MAP 24'hf2f1f0
`define IOFR_RST_ZERO 32'h00000000

`endif

// [rtl/iofr_pkg.sv]
// Purpose: types of the io function router
// Assumes: input codes one byte, output codes one nibble
// Notes: unused slot codes simply match no function
package iofr_pkg;

    typedef logic [7:0] iofr_code_t;
    typedef logic [3:0] iofr_ocode_t;

    // active routing set, applied as one unit
    typedef struct packed {
        logic [2:0] out_pol;
        logic [7:0] in_pol;
        iofr_ocode_t [5:0] out_map;
        iofr_code_t [15:0] in_map;
    } iofr_cfg_t;

endpackage

// [rtl/iofr_src_select.sv]
// Purpose: picks one source per input function
// Assumes: source 0 ranks highest, last source lowest
// Notes: purely combinational
`timescale 1ns/1ps
module iofr_src_select #(
    parameter int NSRC = 16,
    parameter int NFUNC = 26
) (
    // clock and reset for checks
    input wire logic i_clk,
    input wire logic i_rstn,
    // sources
    input wire iofr_pkg::iofr_code_t [NSRC-1:0] i_codes,
    input wire logic [NSRC-1:0] i_lvl,
    // functions
    output logic [NFUNC-1:0] o_func
);

    // ---------------------------------------------------------------
    // per-function priority pick
    // ---------------------------------------------------------------
    genvar gf;
    generate
        for (gf = 0; gf < NFUNC; gf++) begin : g_func
            always_comb begin
                o_func[gf] = 1'b0;
                // scan low rank first so the top rank writes last
                for (int s = NSRC - 1; s >= 0; s--) begin
                    if (i_codes[s] == 8'(gf)) begin
                        o_func[gf] = i_lvl[s];
                    end
                end
            end

            top_rank_a: assert property (
                @(posedge i_clk) disable iff (!i_rstn)
                (i_codes[0] == 8'(gf)) |-> (o_func[gf] == i_lvl[0]))
                else $error("top source does not own its function");

            // any higher-ranked source claiming this code
            logic rival;
            always_comb begin
                rival = 1'b0;
                for (int s = 0; s < NSRC - 1; s++) begin
                    if (i_codes[s] == 8'(gf)) begin
                        rival = 1'b1;
                    end
                end
            end

            low_rank_a: assert property (
                @(posedge i_clk) disable iff (!i_rstn)
                (i_codes[NSRC-1] == 8'(gf) && !rival) |->
                (o_func[gf] == i_lvl[NSRC-1]))
                else $error("last source lost with no rival");
        end
    endgenerate

endmodule // iofr_src_select

// [bench/iofr_field_model.sv]
// Purpose: field switches and drive status facing the router
// Assumes: switch and status levels move only on a load request
// Notes: behavioural; levels hold between loads like real contacts
`timescale 1ns/1ps
module iofr_field_model (
    // clock
    input wire logic i_clk,
    // load request from the bench
    input wire logic i_load,
    input wire logic [7:0] i_sw_nxt,
    input wire logic [9:0] i_stat_nxt,
    // connector pins and drive status
    output logic [7:0] o_pins = 8'h00,
    output logic [9:0] o_stat = 10'h000
);
    always @(posedge i_clk) begin
        if (i_load) begin
            o_pins <= i_sw_nxt;
            o_stat <= i_stat_nxt;
        end
    end
endmodule // iofr_field_model

// [bench/iofr_router_tb.sv]
// Purpose: self-checking bench of the io function router
// Assumes: register port read data valid one cycle after the strobe
// Notes: random maps, pins and status compared with a queue-free model
`timescale 1ns/1ps
`include "iofr_defines.svh"
module io_function_allocation_router_tb_top;
    logic clk, rstn, wr, rd, load;
    logic [7:0] addr, sw_nxt, pins;
    logic [31:0] wdata, rdata, d;
    logic [9:0] stat_nxt, stat;
    logic [25:0] funcs;
    logic [2:0] outs;
    logic [31:0] regs [0:7];
    logic [31:0] act [0:7];
    logic [31:0] gmask [0:7];
    int err_count, n_checks, cycles, seed, i, n;

    iofr_field_model iofr_field_model_inst (.i_clk(clk), .i_load(load),
        .i_sw_nxt(sw_nxt), .i_stat_nxt(stat_nxt), .o_pins(pins),
        .o_stat(stat));
    iofr_router #(.NPIN(8), .NVIN(8), .NGRP(3)) iofr_router_inst (
        .i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pins(pins),
        .i_out_funcs(stat), .o_funcs(funcs), .o_out_pins(outs));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    function automatic logic [25:0] m_funcs();
        logic [25:0] r;
        logic [25:0] taken;
        logic lvl;
        int c;
        r = '0;
        taken = '0;
        for (int s = 0; s < 16; s++) begin
            c = act[s / 4][8 * (s % 4) +: 8];
            lvl = (s < 8) ? pins[s] ^ act[6][s] : regs[5][s - 8];
            if (c < 26 && !taken[c]) begin
                taken[c] = 1'b1;
                r[c] = lvl;
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] m_outs();
        logic [2:0] r;
        logic v;
        int c;
        for (int g = 0; g < 3; g++) begin
            v = 1'b0;
            for (int k = 0; k < 2; k++) begin
                c = act[4][4 * (2 * g + k) +: 4];
                if (c < 10) v = v | stat[c];
                else if (c < 13) v = v | regs[7][c - 10];
            end
            r[g] = v ^ act[6][8 + g];
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a < 8'h20) regs[a[4:2]] = v;
        if (a == `IOFR_OFS_APPLY && v[`IOFR_APPLY_BIT]) act = regs;
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic drive_field(input logic [7:0] p, input logic [9:0] s);
        sw_nxt <= p;
        stat_nxt <= s;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
        chk({6'h00, funcs}, {6'h00, m_funcs()});
        chk({29'h0, outs}, {29'h0, m_outs()});
    endtask

    task automatic close_out();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // hang guard
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h0b72941e;
        err_count = 0;
        n_checks = 0;
        cycles = 0;
        rstn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        load = 1'b0;
        addr = 8'h00;
        wdata = 32'h00000000;
        sw_nxt = 8'h00;
        stat_nxt = 10'h000;
        regs = '{`IOFR_RST_IN_MAP_A, `IOFR_RST_IN_MAP_B, `IOFR_RST_VIN_MAP,
            `IOFR_RST_VIN_MAP, {8'h00, `IOFR_RST_OUT_MAP}, 32'h0, 32'h0,
            32'h0};
        act = regs;
        gmask = '{32'h1f1f1f1f, 32'h1f1f1f1f, 32'h1f1f1f1f, 32'h1f1f1f1f,
            32'h00ffffff, 32'h000000ff, 32'h000007ff, 32'h00000007};
        repeat (12) @(posedge clk);
        #1;
        chk({6'h00, funcs}, 32'h0);
        chk({29'h0, outs}, 32'h0);
        rstn <= 1'b1;
        @(posedge clk);
        // reset values, unmapped address, one-cycle read data
        for (i = 0; i < 8; i++) begin
            rd_reg(8'(i * 4), d);
            chk(d, regs[i]);
        end
        rd_reg(8'h30, d);
        chk(d, 32'h0);
        rd_reg(`IOFR_OFS_IN_MAP_A, d);
        chk(d, `IOFR_RST_IN_MAP_A);
        @(posedge clk);
        #1 chk(rdata, 32'h0);
        // two-edge input path with default allocation
        drive_field(8'h01, 10'h000);
        @(posedge clk);
        #1 chk({31'h0, funcs[0]}, 32'h0);
        @(posedge clk);
        #1 chk({31'h0, funcs[0]}, 32'h1);
        // read-only status ignores writes
        wr_reg(`IOFR_OFS_FUNC_STAT, 32'hffffffff);
        wr_reg(8'h3c, 32'hffffffff);
        rd_reg(`IOFR_OFS_FUNC_STAT, d);
        chk(d, {6'h00, m_funcs()});
        // reserved code on pin 0, empty groups, remote bit on group 2
        wr_reg(`IOFR_OFS_IN_MAP_A, 32'hffffff1a);
        wr_reg(`IOFR_OFS_IN_MAP_B, 32'hffffffff);
        wr_reg(`IOFR_OFS_OUT_MAP, 32'h00faffff);
        wr_reg(`IOFR_OFS_REMOTE, 32'h00000001);
        wr_reg(`IOFR_OFS_APPLY, 32'h1);
        settle();
        chk({6'h00, funcs}, 32'h0);
        chk({29'h0, outs}, 32'h4);
        // random maps, polarity, pins, virtual bits and status
        for (n = 0; n < 40; n++) begin
            for (i = 0; i < 8; i++) begin
                wr_reg(8'(i * 4), $random(seed) & gmask[i]);
            end
            settle();
            drive_field(8'($random(seed)), 10'($random(seed)));
            wr_reg(`IOFR_OFS_APPLY, 32'h1);
            settle();
            for (i = 0; i < 8; i++) begin
                rd_reg(8'(i * 4), d);
                chk(d, regs[i]);
            end
        end
        close_out();
    end
endmodule // io_function_allocation_router_tb_top
